// ### cwdt_pkg.sv
package cwdt_pkg;
  // Timeout interval in milliseconds and the clock rate in kHz.
  localparam int TIMEOUT_MS = 1600;
  localparam int CLK_KHZ = 50000;
  // Longest allowed time converts exactly to whole cycles.
  localparam longint TIMEOUT_CYC_L = longint'(TIMEOUT_MS) * CLK_KHZ;
  localparam int TIMEOUT_CYC = int'(TIMEOUT_CYC_L);
  localparam int CNT_W = 32;

  // Board-level mode selector encoding.
  typedef enum logic [1:0] {
    CWDT_MODE_OFF = 2'h0,
    CWDT_MODE_RESET = 2'h1,
    CWDT_MODE_NMI = 2'h2
  } cwdt_mode_t;

  // Software request strobes from the processor core.
  typedef struct packed {
    logic enable;
    logic clear;
    logic disable_wd;
  } cwdt_req_t;

  typedef enum logic [1:0] {
    CWDT_IDLE = 2'b00,
    CWDT_RUN = 2'b01,
    CWDT_TRIP = 2'b11
  } cwdt_state_t;

  typedef struct packed {
    cwdt_state_t st;
    logic [CNT_W-1:0] cnt;
    logic cpu_rst;
    logic nmi;
  } cwdt_regs_t;

  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
endpackage : cwdt_pkg

// ### cwdt_top.sv
`timescale 1ns/100ps
// Functional notes
// - Inactive, no reset or interrupt, until software enables it.
// - Missed clear trips: processor reset or NMI by selected mode.
// - Clear requests are accepted while enabled and prevent the trip.
// - Software disables before program end; timing then stops.
// - Board selector chooses disabled, reset on timeout, or NMI.
module cwdt_top #(
  parameter int TIMEOUT_CYCLES = cwdt_pkg::TIMEOUT_CYC
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire cwdt_pkg::cwdt_req_t REQ_IN,
  input wire cwdt_pkg::cwdt_mode_t WATCHDOG_MODE_SELECTOR_IN,
  output logic ENABLED_OUT,
  output logic CPU_RESET_OUT,
  output logic NMI_OUT
);
  import cwdt_pkg::*;

  // A limit below two cycles leaves no room to count, and a larger one
  // would not fit the signed int parameter; the count compare is unsigned.
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 32'h7FFF_FFFF) begin : g_bad
    $error("TIMEOUT_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYCLES - 1);

  // Off position of the strap; any other code lets the watchdog run.
  function automatic logic mode_live(input cwdt_mode_t m);
    return m != CWDT_MODE_OFF;
  endfunction : mode_live

  cwdt_regs_t r_q;
  cwdt_regs_t r_d;

  always_comb begin
    r_d = r_q;
    r_d.cpu_rst = 1'b0;
    unique case (r_q.st)
      CWDT_IDLE: begin
        r_d.cnt = CNT_RST;
        // The selector in the off position blocks enabling altogether.
        if (REQ_IN.enable && WATCHDOG_MODE_SELECTOR_IN != CWDT_MODE_OFF) begin
          r_d.st = CWDT_RUN;
        end
      end
      CWDT_RUN: begin
        if (REQ_IN.disable_wd || WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_OFF) begin
          r_d.st = CWDT_IDLE;
          r_d.cnt = CNT_RST;
        end else if (REQ_IN.clear) begin
          r_d.cnt = CNT_RST;
        end else if (r_q.cnt >= LIMIT) begin
          r_d.st = CWDT_TRIP;
          r_d.cnt = CNT_RST;
          if (WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_RESET) begin
            r_d.cpu_rst = 1'b1;
          end else begin
            r_d.nmi = 1'b1;
          end
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      CWDT_TRIP: begin
        // A reset trip returns to idle, since the processor restarts.
        // An NMI holds until software clears or disables, or the selector goes to off.
        if (!r_q.nmi || REQ_IN.disable_wd || REQ_IN.clear
            || WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_OFF) begin
          r_d.nmi = 1'b0;
          r_d.st = r_q.nmi && REQ_IN.clear && !REQ_IN.disable_wd
                   && WATCHDOG_MODE_SELECTOR_IN != CWDT_MODE_OFF
                   ? CWDT_RUN : CWDT_IDLE;
        end
      end
      default: begin
        r_d.st = CWDT_IDLE;
        r_d.nmi = 1'b0;
        r_d.cnt = CNT_RST;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      r_q <= '{st: CWDT_IDLE, cnt: CNT_RST, cpu_rst: 1'b0, nmi: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // A reset trip does not count as enabled: the processor restarts and
  // must enable the watchdog again.
  assign ENABLED_OUT = r_q.st == CWDT_RUN
                       || (r_q.st == CWDT_TRIP && r_q.nmi);
  assign CPU_RESET_OUT = r_q.cpu_rst;
  assign NMI_OUT = r_q.nmi;

  sequence s_run_unserved;
    r_q.st == CWDT_RUN && !REQ_IN.clear && !REQ_IN.disable_wd
      && WATCHDOG_MODE_SELECTOR_IN != CWDT_MODE_OFF;
  endsequence

  idle_quiet_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $past(r_q.st) == CWDT_IDLE |-> !CPU_RESET_OUT && !NMI_OUT)
    else $error("Output raised while idle.");

  trip_reset_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (s_run_unserved and r_q.cnt == LIMIT
     and WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_RESET) |=> CPU_RESET_OUT)
    else $error("Reset trip missing.");

  trip_nmi_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (s_run_unserved and r_q.cnt == LIMIT
     and WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_NMI) |=> NMI_OUT)
    else $error("NMI trip missing.");

  clear_restart_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    r_q.st == CWDT_RUN && REQ_IN.clear |=> r_q.cnt == 0 && !CPU_RESET_OUT
    && !NMI_OUT)
    else $error("Clear did not restart the count.");

  count_step_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    s_run_unserved and r_q.cnt < LIMIT |=> r_q.cnt == $past(r_q.cnt) + 1)
    else $error("Count did not advance.");

  disable_stop_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    REQ_IN.disable_wd && !REQ_IN.enable |=> !ENABLED_OUT && !NMI_OUT)
    else $error("Disable did not stop timing.");

  mode_off_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_OFF |=> !ENABLED_OUT)
    else $error("Off mode left watchdog enabled.");

  pulse_one_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    CPU_RESET_OUT |=> !CPU_RESET_OUT && !ENABLED_OUT)
    else $error("Reset pulse too long.");

  sequence s_idle_enable;
    r_q.st == CWDT_IDLE && REQ_IN.enable
      && mode_live(WATCHDOG_MODE_SELECTOR_IN);
  endsequence

  sequence s_trip_due;
    s_run_unserved ##0 r_q.cnt == LIMIT;
  endsequence

  sequence s_nmi_waiting;
    NMI_OUT && !REQ_IN.clear && !REQ_IN.disable_wd
      && mode_live(WATCHDOG_MODE_SELECTOR_IN);
  endsequence

  // The checks below cover entry and routing of each trip kind and exit of the NMI trip, so a
  // wrong mode decode shows up at the trip rather than much later.
  enable_start_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN) s_idle_enable |=> ENABLED_OUT && r_q.cnt == 0)
    else $error("Enable did not start the watchdog.");

  idle_refuse_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    r_q.st == CWDT_IDLE && !REQ_IN.enable |=> !ENABLED_OUT)
    else $error("Watchdog started without enable.");

  enable_ignored_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    s_run_unserved ##0 REQ_IN.enable && r_q.cnt < LIMIT
    |=> r_q.cnt == $past(r_q.cnt) + 1)
    else $error("Enable while running disturbed the count.");

  nmi_hold_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN) s_nmi_waiting |=> NMI_OUT && ENABLED_OUT)
    else $error("NMI dropped without a request.");

  nmi_resume_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    NMI_OUT && REQ_IN.clear && !REQ_IN.disable_wd
    && mode_live(WATCHDOG_MODE_SELECTOR_IN)
    |=> !NMI_OUT && ENABLED_OUT && r_q.cnt == 0)
    else $error("Clear did not resume after NMI.");

  nmi_drop_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    NMI_OUT && (REQ_IN.disable_wd || !mode_live(WATCHDOG_MODE_SELECTOR_IN))
    |=> !NMI_OUT && !ENABLED_OUT)
    else $error("Disable did not end the NMI.");

  trip_exclusive_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN) !(CPU_RESET_OUT && NMI_OUT))
    else $error("Both trip outputs high.");

  count_bound_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN) r_q.cnt <= LIMIT)
    else $error("Count passed the limit.");

  no_early_trip_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    s_run_unserved ##0 r_q.cnt < LIMIT |=> !CPU_RESET_OUT && !NMI_OUT)
    else $error("Trip before the limit.");

  disable_clear_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    r_q.st == CWDT_RUN && REQ_IN.disable_wd |=> r_q.cnt == 0)
    else $error("Disable left the count running.");

  reset_route_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    s_trip_due ##0 WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_RESET
    |=> !NMI_OUT && !ENABLED_OUT)
    else $error("Reset mode trip took the wrong route.");

  nmi_route_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    s_trip_due ##0 WATCHDOG_MODE_SELECTOR_IN != CWDT_MODE_RESET
    |=> !CPU_RESET_OUT && ENABLED_OUT)
    else $error("NMI mode trip took the wrong route.");

  off_no_trip_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    WATCHDOG_MODE_SELECTOR_IN == CWDT_MODE_OFF |=> !CPU_RESET_OUT && !NMI_OUT)
    else $error("Trip output in off mode.");

  reset_same_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN) CPU_RESET_OUT |-> !ENABLED_OUT)
    else $error("Enabled during the reset pulse.");

  reset_entry_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    $rose(CPU_RESET_OUT) |-> $past(r_q.st) == CWDT_RUN)
    else $error("Reset pulse not from a running watchdog.");

  nmi_entry_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_N_IN)
    $rose(NMI_OUT) |-> $past(r_q.cnt) == LIMIT)
    else $error("NMI raised before the limit.");
endmodule : cwdt_top

// ### cwdt_cpu_model.sv
`timescale 1ns/100ps
// Software side: clears in time unless told to stall, which forces trips.
module cwdt_cpu_model #(parameter int T = 16) (
  input wire logic clk_in,
  input wire logic [31:0] rnd_in,
  input wire logic stall_in,
  output cwdt_pkg::cwdt_req_t req_out
);
  import cwdt_pkg::*;
  int gap = 0;
  initial req_out = '0;
  always @(posedge clk_in) begin
    req_out.enable <= rnd_in[3:0] == 4'h0;
    req_out.disable_wd <= rnd_in[13:8] == 6'h00;
    req_out.clear <= !stall_in && (rnd_in[6:4] == 3'h0 || gap > T - 4);
    gap <= req_out.clear ? 0 : gap + 1;
  end
endmodule : cwdt_cpu_model

// ### tb_cpu_watchdog_timer.sv
`timescale 1ns/100ps
module tb_cpu_watchdog_timer;
  import cwdt_pkg::*;
  localparam int T = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic [31:0] rnd = 32'h0001_0123;
  cwdt_mode_t mode = CWDT_MODE_RESET;
  cwdt_req_t req;
  logic en, crst, nmi;
  int error_cnt = 0;
  int total_checks = 0;
  int st = 0;
  int cnt = 0;
  cwdt_cpu_model #(.T(T)) u_cpu (.clk_in(clk), .rnd_in(rnd),
    .stall_in(stall), .req_out(req));
  cwdt_top #(.TIMEOUT_CYCLES(T)) u_dut (.CORE_CLK_IN(clk),
    .RST_N_IN(rst_n), .REQ_IN(req), .WATCHDOG_MODE_SELECTOR_IN(mode),
    .ENABLED_OUT(en), .CPU_RESET_OUT(crst), .NMI_OUT(nmi));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic final_report();
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [2:0] exp, input logic [2:0] act);
    total_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, act);
    end
  endtask : chk
  initial begin
    forever #10 clk = ~clk;
  end
  // Reference: 0 idle, 1 running, 2 reset pulse, 3 interrupt held.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st = 0;
      cnt = 0;
    end else case (st)
      0: if (req.enable && mode != CWDT_MODE_OFF) begin
        st = 1;
        cnt = 0;
      end
      1: if (req.disable_wd || mode == CWDT_MODE_OFF) st = 0;
        else if (req.clear) cnt = 0;
        else if (cnt == T - 1) st = (mode == CWDT_MODE_RESET) ? 2 : 3;
        else cnt++;
      2: st = 0;
      3: if (req.disable_wd || mode == CWDT_MODE_OFF) st = 0;
        else if (req.clear) begin
          st = 1;
          cnt = 0;
        end
    endcase
  end
  always @(negedge clk) begin
    chk({st == 1 || st == 3, st == 2, st == 3}, {en, crst, nmi});
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6000; i++) begin
      @(posedge clk);
      rnd <= xs(rnd);
      stall <= i[8];
      if (rnd[31:26] == 6'h00) mode <= cwdt_mode_t'(rnd[21:20]);
      rst_n <= !(i inside {[3000:3002]});
    end
    final_report();
  end
  // Run needs about 6010 cycles; the limit leaves ample margin.
  initial begin
    #200_000;
    error_cnt++;
    final_report();
  end
endmodule : tb_cpu_watchdog_timer
